//--- ast_pkg.sv
// constants, field layouts and types of the serial transmitter
// assumes a single 100 MHz core clock and the simple register port
package ast_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 32'h0000_000a; // 10 ns core period
    localparam int US_NS         = 32'h0000_03e8; // one microsecond
    localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
    localparam int MS_US         = 32'h0000_03e8; // microseconds per ms
    localparam logic [13:0] EXTRA_US = 14'h0014;  // fixed bit stretch

    // register port widths
    localparam int ADDR_W = 32'h0000_0005;
    localparam int DATA_W = 32'h0000_0010;

    // register addresses
    localparam logic [4:0] A_FORMAT = 5'h00; // line format word
    localparam logic [4:0] A_PACE   = 5'h01; // gap between bytes, ms
    localparam logic [4:0] A_TMO    = 5'h02; // flow wait limit, ms
    localparam logic [4:0] A_PINS   = 5'h03; // pin selection
    localparam logic [4:0] A_CMD    = 5'h04; // write: command, read: status
    localparam int         MEM_BIT  = 32'h0000_0004; // addr bit for array

    // reset values
    localparam logic [15:0] FORMAT_RST = 16'h0000;
    localparam logic [15:0] PACE_RST   = 16'h0000;
    localparam logic [15:0] TMO_RST    = 16'h0000;
    localparam logic [9:0]  PINS_RST   = 10'h000;

    // pin selection fields
    localparam int PIN_TX_LSB  = 32'h0000_0000; // 5 bits, 0..16
    localparam int PIN_FL_LSB  = 32'h0000_0005; // 4 bits, 0..15
    localparam int PIN_FL_EN   = 32'h0000_0009; // flow check enable
    localparam int NPINS       = 32'h0000_0011; // 16 general + dedicated
    localparam logic [4:0] DED_PIN = 5'h10;      // dedicated serial out

    // command fields
    localparam int CMD_KIND_LSB = 32'h0000_0000;
    localparam int CMD_VAL_LSB  = 32'h0000_0008;

    // status bits
    localparam int ST_BUSY = 32'h0000_0000;
    localparam int ST_TMO  = 32'h0000_0001;
    localparam int ST_DONE = 32'h0000_0002;

    // byte array
    localparam int MEM_DEPTH = 32'h0000_0010;
    localparam logic [7:0] ASCII_ZERO = 8'h30;

    // character frame: start, 8 slots, stop
    localparam logic [3:0] FRAME_BITS = 4'ha;

    // line format word
    typedef struct packed {
        logic        open_drive; // drive one level only
        logic        invert;     // inverted levels
        logic        seven_even; // 7 data bits plus even parity
        logic [12:0] period_us;  // bit time less the fixed stretch
    } ast_fmt_t;

    // what a send command transmits
    typedef enum logic [1:0] {
        K_BYTE     = 2'h0, // one raw byte
        K_DEC      = 2'h1, // decimal text of a value
        K_NULLTERM = 2'h2, // array up to a zero byte
        K_COUNTED  = 2'h3  // array, given length
    } ast_kind_t;

    // sequencer states, gray along fetch-pace-flow-send
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_FETCH = 3'h1,
        S_PACE  = 3'h3,
        S_FLOW  = 3'h2,
        S_SEND  = 3'h6
    } ast_state_t;

endpackage

//--- ast_tick.sv
// divider that turns an enable stream into a slower one-cycle tick
// assumes en is a one-cycle pulse or held high, in the core domain
module ast_tick #(
    parameter int DIV = 100
) (
    input  wire logic core_clk, // core clock
    input  wire logic nrst,     // async reset, active low
    input  wire logic en,       // counts only when high
    output logic      tick      // one pulse every DIV enables
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt; // enables seen so far

    // count enables, pulse and wrap at the end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cnt == CW'(DIV - 1)) begin
                    cnt  <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

endmodule

//--- ast_char.sv
// shifts one framed character out at a microsecond-based bit time
// assumes us_tick is a one-cycle pulse once per microsecond
module ast_char (
    input  wire logic             core_clk, // core clock
    input  wire logic             nrst,     // async reset, active low
    input  wire logic             us_tick,  // microsecond enable
    input  wire logic             start,    // begin a character
    input  wire logic [7:0]       data,     // byte to send
    input  wire ast_pkg::ast_fmt_t fmt,     // format of this send
    output logic                  line,     // logical level, 1 = idle
    output logic                  busy,     // character in flight
    output logic                  done      // pulse after stop bit
);

    logic [9:0]  shreg; // frame, lsb goes out now
    logic [3:0]  left;  // frame slots still to finish
    logic [13:0] ucnt;  // microseconds into this slot
    logic [13:0] last;  // final microsecond of a slot
    logic        par;   // even parity over seven bits
    logic [9:0]  frame; // frame built from data

    // bit time is the field plus the fixed stretch
    assign last = {1'b0, fmt.period_us} + ast_pkg::EXTRA_US
                  - 14'h0001;
    assign par  = ^data[6:0];

    // start, data lsb first, parity or eighth bit, stop
    always_comb begin
        if (fmt.seven_even) begin
            frame = {1'b1, par, data[6:0], 1'b0};
        end else begin
            frame = {1'b1, data, 1'b0};
        end
    end

    // slot timing and shifting
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shreg <= '1;
            left  <= '0;
            ucnt  <= '0;
            line  <= 1'b1;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                // load frame, start bit goes out at once
                shreg <= frame;
                line  <= frame[0];
                left  <= ast_pkg::FRAME_BITS;
                ucnt  <= '0;
                busy  <= 1'b1;
            end else if (busy && us_tick) begin
                if (ucnt == last) begin
                    // slot over, move to the next one
                    ucnt  <= '0;
                    shreg <= {1'b1, shreg[9:1]};
                    left  <= left - 1'b1;
                    if (left == 4'h1) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        line <= 1'b1; // idle between characters
                    end else begin
                        line <= shreg[1];
                    end
                end else begin
                    ucnt <= ucnt + 1'b1;
                end
            end
        end
    end

endmodule

//--- ast_top.sv
// asynchronous serial transmitter with register port and pin bank
// assumes pin inputs synchronous to core_clk; one-cycle strobes
//
// How it works
// - one 16-bit format word per send
// - low thirteen bits give bit period
// - each bit lasts field plus 20 us
// - bit 13 picks 8N or 7E
// - 7E format carries values 0 to 127
// - bit 14 inverts every output level
// - bit 15 selects driving one level only
// - open mode drives high inverted, low otherwise
// - dedicated pin always inverted; flow keeps polarity
// - send makes transmit pin an output first
// - pacing waits given ms between bytes
// - literal bytes sent in order, unconverted
// - decimal modifier sends value as digits
// - array sends to zero or given count
// - check flow permission before each byte
// - permission level follows output polarity
// - no permission within timeout aborts send
module ast_top (
    input  wire logic        core_clk,  // 100 MHz core clock
    input  wire logic        nrst,      // async reset, active low
    input  wire logic [4:0]  reg_addr,  // register address
    input  wire logic [15:0] reg_wdata, // write data
    input  wire logic        reg_wr,    // write strobe
    input  wire logic        reg_rd,    // read strobe
    output logic      [15:0] reg_rdata, // read data, cycle after strobe
    input  wire logic [15:0] pin_in,    // general pin levels
    output logic      [16:0] pin_out,   // pin output levels
    output logic      [16:0] pin_oe,    // pin output enables
    output logic             send_busy  // a send is in progress
);

    // programmed registers
    ast_pkg::ast_fmt_t fmt_reg;  // format for the next send
    logic [15:0]       pace_reg; // gap between bytes, ms
    logic [15:0]       tmo_reg;  // flow wait limit, ms
    logic [9:0]        pins_reg; // transmit and flow pin selection
    logic [7:0]        mem [ast_pkg::MEM_DEPTH]; // byte array

    // latched at command start
    ast_pkg::ast_fmt_t cur_fmt;   // format in use
    ast_pkg::ast_kind_t cur_kind; // what is being sent
    logic [7:0]        cur_val;   // value or count
    logic [4:0]        cur_tx;    // transmit pin
    logic [3:0]        cur_fl;    // flow pin
    logic              cur_flen;  // flow check enabled

    // sequencer
    ast_pkg::ast_state_t state;  // sequencer state
    logic [7:0]        idx;      // byte index within the send
    logic              first;    // no byte sent yet
    logic [15:0]       mcnt;     // ms elapsed in pace or flow wait
    logic [7:0]        cur_byte; // byte being sent
    logic              tmo_flag; // last send aborted on flow wait
    logic              done_flag; // last send finished normally
    logic              cstart;   // start pulse to the shifter
    logic [16:0]       dir;      // pins switched to output

    // time base and shifter
    logic us_tick; // once per microsecond
    logic ms_tick; // once per millisecond
    logic line;    // logical serial level
    logic cbusy;   // character in flight
    logic cdone;   // character finished

    // command decode
    logic is_mem;  // address in the array window
    logic cmd_go;  // accepted send command
    assign is_mem = reg_addr[ast_pkg::MEM_BIT];
    assign cmd_go = reg_wr && !is_mem && reg_addr == ast_pkg::A_CMD &&
                    state == ast_pkg::S_IDLE;
    assign send_busy = state != ast_pkg::S_IDLE;

    // microsecond and millisecond enables
    ast_tick #(.DIV(ast_pkg::CYC_PER_US)) u_us (
        .core_clk (core_clk),
        .nrst     (nrst),
        .en       (1'b1),
        .tick     (us_tick)
    );

    ast_tick #(.DIV(ast_pkg::MS_US)) u_ms (
        .core_clk (core_clk),
        .nrst     (nrst),
        .en       (us_tick),
        .tick     (ms_tick)
    );

    ast_char u_char (
        .core_clk (core_clk),
        .nrst     (nrst),
        .us_tick  (us_tick),
        .start    (cstart),
        .data     (cur_byte),
        .fmt      (cur_fmt),
        .line     (line),
        .busy     (cbusy),
        .done     (cdone)
    );

    // settings registers, written at any time
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fmt_reg  <= ast_pkg::FORMAT_RST;
            pace_reg <= ast_pkg::PACE_RST;
            tmo_reg  <= ast_pkg::TMO_RST;
            pins_reg <= ast_pkg::PINS_RST;
        end else if (reg_wr && !is_mem) begin
            case (reg_addr)
                ast_pkg::A_FORMAT: fmt_reg  <= reg_wdata;
                ast_pkg::A_PACE:   pace_reg <= reg_wdata;
                ast_pkg::A_TMO:    tmo_reg  <= reg_wdata;
                ast_pkg::A_PINS:   pins_reg <= reg_wdata[9:0];
                default: ;
            endcase
        end
    end

    // byte array, no reset needed for data
    always_ff @(posedge core_clk) begin
        if (reg_wr && is_mem) begin
            mem[reg_addr[3:0]] <= reg_wdata[7:0];
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (is_mem) begin
            reg_rdata <= {8'h00, mem[reg_addr[3:0]]};
        end else begin
            case (reg_addr)
                ast_pkg::A_FORMAT: reg_rdata <= fmt_reg;
                ast_pkg::A_PACE:   reg_rdata <= pace_reg;
                ast_pkg::A_TMO:    reg_rdata <= tmo_reg;
                ast_pkg::A_PINS:   reg_rdata <= {6'h00, pins_reg};
                ast_pkg::A_CMD:    reg_rdata <= {13'h0000, done_flag,
                                                 tmo_flag, send_busy};
                default:           reg_rdata <= '0;
            endcase
        end
    end

    // decimal digits of the value, no leading zeros
    logic [7:0] dig_h;   // hundreds
    logic [7:0] dig_t;   // tens
    logic [7:0] dig_o;   // ones
    logic [1:0] ndig;    // digit count
    logic [7:0] dec_chr; // digit text for this index
    logic [7:0] dsel;    // position among three digits
    assign dig_h = cur_val / 8'h64;
    assign dig_t = (cur_val / 8'h0a) % 8'h0a;
    assign dig_o = cur_val % 8'h0a;
    assign ndig  = (cur_val >= 8'h64) ? 2'h3 :
                   (cur_val >= 8'h0a) ? 2'h2 : 2'h1;
    assign dsel  = idx + 8'h03 - {6'h00, ndig};

    always_comb begin
        case (dsel)
            8'h00:   dec_chr = ast_pkg::ASCII_ZERO + dig_h;
            8'h01:   dec_chr = ast_pkg::ASCII_ZERO + dig_t;
            default: dec_chr = ast_pkg::ASCII_ZERO + dig_o;
        endcase
    end

    // next byte of the send and whether one remains
    logic       have;     // a byte remains
    logic [7:0] nxt_byte; // that byte
    logic [7:0] mbyte;    // array entry at idx
    assign mbyte = mem[idx[3:0]];

    always_comb begin
        case (cur_kind)
            ast_pkg::K_BYTE: begin
                have     = idx == 8'h00;
                nxt_byte = cur_val;
            end
            ast_pkg::K_DEC: begin
                have     = idx < {6'h00, ndig};
                nxt_byte = dec_chr;
            end
            ast_pkg::K_NULLTERM: begin
                have     = idx < 8'h10 && mbyte != 8'h00;
                nxt_byte = mbyte;
            end
            default: begin
                have     = idx < cur_val;
                nxt_byte = mbyte;
            end
        endcase
    end

    // permission: go is high when inverted, low when not
    logic permit; // flow pin shows go
    assign permit = pin_in[cur_fl] == cur_fmt.invert;

    // send sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state     <= ast_pkg::S_IDLE;
            cur_fmt   <= ast_pkg::FORMAT_RST;
            cur_kind  <= ast_pkg::K_BYTE;
            cur_val   <= '0;
            cur_tx    <= '0;
            cur_fl    <= '0;
            cur_flen  <= 1'b0;
            idx       <= '0;
            first     <= 1'b1;
            mcnt      <= '0;
            cur_byte  <= '0;
            tmo_flag  <= 1'b0;
            done_flag <= 1'b0;
            cstart    <= 1'b0;
        end else begin
            cstart <= 1'b0;
            case (state)
                ast_pkg::S_IDLE: begin
                    if (cmd_go) begin
                        // take format, kind, value and pins now; pace and timeout stay live
                        cur_fmt   <= fmt_reg;
                        cur_kind  <= ast_pkg::ast_kind_t'(reg_wdata[1:0]);
                        cur_val   <= reg_wdata[15:8];
                        cur_tx    <= pins_reg[4:0];
                        cur_fl    <= pins_reg[8:5];
                        cur_flen  <= pins_reg[ast_pkg::PIN_FL_EN];
                        idx       <= '0;
                        first     <= 1'b1;
                        tmo_flag  <= 1'b0;
                        done_flag <= 1'b0;
                        state     <= ast_pkg::S_FETCH;
                    end
                end
                ast_pkg::S_FETCH: begin
                    mcnt <= '0;
                    if (!have) begin
                        done_flag <= 1'b1;
                        state     <= ast_pkg::S_IDLE;
                    end else begin
                        cur_byte <= nxt_byte;
                        if (!first && pace_reg != 16'h0000) begin
                            state <= ast_pkg::S_PACE;
                        end else begin
                            state <= ast_pkg::S_FLOW;
                        end
                    end
                end
                ast_pkg::S_PACE: begin
                    // gap counted in whole ms ticks
                    if (mcnt == pace_reg) begin
                        mcnt  <= '0;
                        state <= ast_pkg::S_FLOW;
                    end else if (ms_tick) begin
                        mcnt <= mcnt + 1'b1;
                    end
                end
                ast_pkg::S_FLOW: begin
                    if (!cur_flen || permit) begin
                        cstart <= 1'b1;
                        state  <= ast_pkg::S_SEND;
                    end else if (mcnt == tmo_reg) begin
                        tmo_flag <= 1'b1; // abort the send
                        state    <= ast_pkg::S_IDLE;
                    end else if (ms_tick) begin
                        mcnt <= mcnt + 1'b1;
                    end
                end
                ast_pkg::S_SEND: begin
                    if (cdone) begin
                        idx   <= idx + 1'b1;
                        first <= 1'b0;
                        state <= ast_pkg::S_FETCH;
                    end
                end
                default: state <= ast_pkg::S_IDLE;
            endcase
        end
    end

    // pin directions: transmit pin out, flow pin in only if flow check enabled, both kept after
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dir <= '0;
        end else if (cmd_go) begin
            dir[pins_reg[4:0]] <= 1'b1;
            if (pins_reg[ast_pkg::PIN_FL_EN]) begin
                dir[pins_reg[8:5]] <= 1'b0;
            end
        end
    end

    // physical level and whether it is driven
    logic einv;  // effective inversion
    logic phys;  // pin level for the logical line
    logic drive; // pin actively driven now
    assign einv  = cur_fmt.invert || cur_tx == ast_pkg::DED_PIN;
    assign phys  = line ^ einv;
    // open: inverted drives only high, else only low
    assign drive = !cur_fmt.open_drive || phys == einv;

    // pin outputs, the transmit pin follows the line
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            for (int i = 0; i < ast_pkg::NPINS; i++) begin
                if (5'(i) == cur_tx && dir[i]) begin
                    pin_out[i] <= phys;
                    pin_oe[i]  <= drive;
                end else if (!dir[i]) begin
                    pin_oe[i] <= 1'b0;
                end
            end
        end
    end

endmodule

//--- ast_top_asserts.sv
// checker: timing relations at the transmitter's ports
// assumes bind to ast_top; settings shadowed from register writes
module ast_top_asserts (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] pin_in,
    input wire logic [16:0] pin_out,
    input wire logic [16:0] pin_oe,
    input wire logic        send_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [15:0] fw, pw, tw; // settings as written
    logic [15:0] sf, sp;     // settings of the running send
    logic [31:0] run;        // cycles since tx level change
    logic [3:0]  age;        // cycles since accept, saturating
    logic        txq;        // tx level one cycle back
    logic        acc, inv, tx;
    assign acc = reg_wr && reg_addr == ast_pkg::A_CMD && !send_busy;
    assign inv = sf[14] | (sp[4:0] == ast_pkg::DED_PIN);
    assign tx  = pin_out[sp[4:0]];
    // shadow registers, latch at accept, run and age counters
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fw  <= 16'h0000;
            pw  <= 16'h0000;
            tw  <= 16'h0000;
            sf  <= 16'h0000;
            sp  <= 16'h0000;
            run <= 32'h0000_0000;
            age <= 4'h0;
            txq <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == ast_pkg::A_FORMAT) fw <= reg_wdata;
            if (reg_wr && reg_addr == ast_pkg::A_PINS) pw <= reg_wdata;
            if (reg_wr && reg_addr == ast_pkg::A_TMO) tw <= reg_wdata;
            if (acc) sf <= fw;
            if (acc) sp <= pw;
            txq <= tx;
            run <= (tx != txq) ? 32'h0000_0001 : run + 32'h0000_0001;
            age <= acc ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
        end
    end
    property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
    property p_unmap; reg_rd && reg_addr inside {[5'h05:5'h0f]} |=> reg_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    property p_busy; acc |=> send_busy; endproperty
    a_busy: assert property (p_busy) else $error("send not started");
    property p_idle; acc ##3 !sf[15] |-> pin_oe[sp[4:0]] && tx == !inv; endproperty
    a_idle: assert property (p_idle) else $error("tx idle level wrong");
    property p_flow; acc ##2 (sp[9] && sp[8:5] != sp[4:0]) |-> !pin_oe[sp[8:5]]; endproperty
    a_flow: assert property (p_flow) else $error("flow pin driven");
    property p_tmo; acc && pw[9] && tw == 16'h0000 && pin_in[pw[8:5]] != fw[14]
        |-> ##[1:8] !send_busy; endproperty
    a_tmo: assert property (p_tmo) else $error("no abort at timeout");
    property p_open; send_busy && sf[15] && age == 4'hf |-> pin_oe[sp[4:0]] == (tx == inv); endproperty
    a_open: assert property (p_open) else $error("open drive level wrong");
    property p_slot; send_busy && age == 4'hf && tx != txq
        |-> run >= (int'(sf[12:0]) + 19) * ast_pkg::CYC_PER_US; endproperty
    a_slot: assert property (p_slot) else $error("bit slot too short");
endmodule

//--- ast_rx_model.sv
// receiver model: samples framed characters at mid-slot
// assumes line is the logical level, 1 idle, in the core clock domain
module ast_rx_model #(
    parameter int BIT_CYC = 2000
) (
    input  wire logic  core_clk, // core clock
    input  wire logic  line,     // logical line level
    input  wire logic  seven,    // 7 data bits plus parity
    output logic [7:0] rx_data,  // last character
    output logic [7:0] rx_cnt,   // characters received
    output logic       rx_err    // bad start, stop or parity
);
    logic [7:0] sh = 8'h00; // slots gathered
    initial begin
        rx_data = 8'h00;
        rx_cnt  = 8'h00;
        rx_err  = 1'b0;
    end
    // one character per start edge, lsb first
    always begin
        @(negedge line);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        if (line) rx_err = 1'b1;
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            if (i < 8) sh[i] = line;
            else if (!line) rx_err = 1'b1;
        end
        if (seven && ^sh) rx_err = 1'b1;
        rx_data = seven ? {1'b0, sh[6:0]} : sh;
        rx_cnt  = rx_cnt + 8'h01;
    end
endmodule

//--- ast_top_tb.sv
// testbench: register rows, then sends seen by the receiver model
// assumes ast_pkg, ast_top, model and checker compiled before it
module ast_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0]  a; // address
        logic [15:0] d; // written
        logic [15:0] e; // read back
    } ast_row_t;
    localparam logic [15:0] PER = 16'(1000000 / 50000 - 20);
    logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0;
    logic        reg_rd = 1'b0, sev = 1'b0, inv = 1'b0, rx_on = 1'b0;
    logic [4:0]  reg_addr = 5'h00, tx = 5'h01;
    logic [15:0] reg_wdata = 16'h0000, pin_in = 16'h0000, q;
    logic [15:0] reg_rdata;
    logic [16:0] pin_out, pin_oe;
    logic        send_busy, line, rx_err;
    logic [7:0]  rx_data, rx_cnt;
    int          fails = 0, checks = 0;
    ast_row_t    rows [8] = '{'{5'h00, 16'hffff, 16'hffff},
        '{5'h01, 16'h1234, 16'h1234}, '{5'h01, 16'h0000, 16'h0000},
        '{5'h02, 16'habcd, 16'habcd}, '{5'h02, 16'h0000, 16'h0000},
        '{5'h03, 16'hffff, 16'h03ff}, '{5'h05, 16'hffff, 16'h0000},
        '{5'h13, 16'h1234, 16'h0034}};
    always #5 core_clk = ~core_clk;
    // logical level of the tx pin, a released pin rests at the idle level
    assign line = rx_on ? (pin_oe[tx] ? pin_out[tx] ^ inv : 1'b1) : 1'b1;
    ast_top dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .send_busy(send_busy));
    ast_rx_model #(.BIT_CYC((int'(PER) + 20) * ast_pkg::CYC_PER_US)) rxm (
        .core_clk(core_clk), .line(line), .seven(sev),
        .rx_data(rx_data), .rx_cnt(rx_cnt), .rx_err(rx_err));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // read strobe, data taken in the following cycle
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        q = reg_rdata;
    endtask
    // settings, command, bounded wait, status and received byte
    task automatic send(input logic [15:0] f, p, c, st, input int n,
                        input logic [7:0] e);
        int         k;
        logic [7:0] c0;
        c0  = rx_cnt;
        tx  = p[4:0];
        inv = f[14] | (p[4:0] == ast_pkg::DED_PIN);
        sev = f[13];
        wr(ast_pkg::A_FORMAT, f);
        wr(ast_pkg::A_PINS, p);
        rx_on = (n > 0);
        wr(ast_pkg::A_CMD, c);
        k = 0;
        repeat (2) @(posedge core_clk);
        while (send_busy !== 1'b0 && k < 40000) begin
            @(posedge core_clk);
            k++;
        end
        rx_on = 1'b0;
        if (k == 40000) begin
            fails++;
            end_of_test();
        end
        rd(ast_pkg::A_CMD);
        chk(q, st);
        chk(16'(rx_cnt - c0), 16'(n));
        if (n > 0) chk({8'h00, rx_data}, {8'h00, e});
        chk({15'h0000, rx_err}, 16'h0000);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        chk(pin_oe[15:0] | reg_rdata, 16'h0000);
        chk({15'h0000, send_busy | pin_oe[16]}, 16'h0000);
        nrst <= 1'b1;
        rd(ast_pkg::A_FORMAT);
        chk(q, ast_pkg::FORMAT_RST);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(q, rows[i].e);
        end
        pin_in <= 16'hfffb; // flow pin low
        // raw byte, flow granted, noninverted
        send(PER, 16'h0241, 16'ha500, 16'h0004, 1, 8'ha5);
        // 7E on the dedicated pin, top bit dropped
        send(16'h2000 | PER, 16'h0010, 16'hc100, 16'h0004, 1, 8'h41);
        // decimal text through an open drive pin
        send(16'h8000 | PER, 16'h0001, 16'h0701, 16'h0004, 1, 8'h37);
        // inverted, permission withheld, zero timeout
        send(16'h4000 | PER, 16'h0241, 16'ha500, 16'h0002, 0, 8'h00);
        // array starting with its terminator sends nothing, counted length 1 sends the zero
        wr(5'h10, 16'h0000);
        send(PER, 16'h0001, 16'h0002, 16'h0004, 0, 8'h00);
        send(PER, 16'h0001, 16'h0103, 16'h0004, 1, 8'h00);
        end_of_test();
    end
endmodule
bind ast_top ast_top_asserts chk_i (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .send_busy(send_busy));
